// *** pcbg_pkg.sv ***
// package for the pixel clip, balance and gamma stage
package pcbg_pkg;
  localparam int PIX_W = 10;
  localparam int GAIN_W = 16;
  localparam int GAIN_FRAC = 12;
  localparam int NCH = 8;
  localparam int LUT_DEPTH = 1024;
  localparam int FIFO_DEPTH = 16;
  localparam logic [7:0] ADR_CEIL_SEL = 8'h00;
  localparam logic [7:0] ADR_CEIL_INT = 8'h04;
  localparam logic [7:0] ADR_CEIL_PHYS = 8'h08;
  localparam logic [7:0] ADR_GAIN_SEL = 8'h0C;
  localparam logic [7:0] ADR_GAIN = 8'h10;
  localparam logic [7:0] ADR_AUTO_MODE = 8'h14;
  localparam logic [7:0] ADR_GAMMA_EN = 8'h18;
  localparam logic [7:0] ADR_LUT_IDX = 8'h1C;
  localparam logic [7:0] ADR_LUT_VAL = 8'h20;
  localparam logic [7:0] ADR_STATUS = 8'h24;
  localparam logic [7:0] ADR_AUTO_TARGET = 8'h28;
  localparam logic [3:0] SEL_ALL = 4'h0;
  localparam logic [3:0] SEL_RED = 4'h1;
  localparam logic [3:0] SEL_GREEN = 4'h2;
  localparam logic [3:0] SEL_BLUE = 4'h3;
  localparam logic [3:0] SEL_Y = 4'h4;
  localparam logic [3:0] SEL_U = 4'h5;
  localparam logic [3:0] SEL_V = 4'h6;
  localparam logic [3:0] SEL_TAP1 = 4'h7;
  localparam logic [3:0] SEL_TAP2 = 4'h8;
  localparam logic [1:0] MODE_OFF = 2'h0;
  localparam logic [1:0] MODE_ONCE = 2'h1;
  localparam logic [1:0] MODE_CONT = 2'h2;
  localparam logic [1:0] MODE_VENDOR = 2'h3;
  localparam logic [GAIN_W-1:0] GAIN_RST = 16'h1000;
  localparam logic [PIX_W-1:0] CEIL_RST = 10'h3FF;
  localparam logic [PIX_W-1:0] TARGET_RST = 10'h200;
  localparam logic [PIX_W-1:0] PIX_MAX = 10'h3FF;
  localparam logic [7:0] PHYS_SHIFT = 8'h02;
  localparam logic [9:0] AUTO_TOL = 10'h008;
  typedef struct packed {
    logic [PIX_W-1:0] data;
    logic [3:0]       chan;
  } pcbg_pix_t;
  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } pcbg_bus_t;
endpackage

// *** pcbg_top.sv ***
// pixel clip, balance and gamma stage with its fifo
`timescale 1ns/1ns
`default_nettype none
// What this block does
// R1: output pixel never exceeds ceiling; larger values become the ceiling.
// R2: per-channel ceiling applies only to the channel the selector chose.
// R3: integer and physical ceiling forms always read back consistently.
// R4: the all-channels ceiling applies to every channel, readable independently.
// R5: gain selector offers red, green, blue, Y, U, V and taps.
// R6: selected channel output equals input times its positive gain factor.
// R7: mode off uses only host-written gain factors.
// R8: mode once steps gains per pixel until one lands within tolerance of target, then returns itself to off.
// R9: mode continuous keeps adjusting gains; mode stays until host changes.
// R10: vendor mode value accepted besides off, once and continuous.
// R11: gamma raises each pixel to the gamma power via table.
// R12: table index writes and value reads blocked while gamma active; value writes still land.
// R13: gain multiply saturates at max code, fixed point with fraction bits.
// R14: gamma table indexed by pixel code, reloaded by host on change.
module pcbg_fifo #(
  parameter int W = 14,
  parameter int D = 16
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = $clog2(D);
  logic [W-1:0]  mem [D];
  logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
  logic [AW:0]   cnt_r, cnt_nxt;
  logic          push, pop;
  always_comb begin
    push = in_valid && in_ready;
    pop = out_valid && out_ready;
    wp_nxt = push ? wp_r + 1'b1 : wp_r;
    rp_nxt = pop ? rp_r + 1'b1 : rp_r;
    cnt_nxt = cnt_r;
    if (push && !pop) begin
      cnt_nxt = cnt_r + 1'b1;
    end else if (pop && !push) begin
      cnt_nxt = cnt_r - 1'b1;
    end
  end
  assign in_ready = (cnt_r != D[AW:0]);
  assign out_valid = (cnt_r != '0);
  assign out_data = mem[rp_r];
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wp_r] <= in_data;
    end
    if (!rst_n) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end else begin
      wp_r <= wp_nxt;
      rp_r <= rp_nxt;
      cnt_r <= cnt_nxt;
    end
  end
endmodule // pcbg_fifo

module pcbg_top (
  input  wire logic                    CORE_CLK,
  input  wire logic                    RST_N,
  input  wire pcbg_pkg::pcbg_bus_t     BUS,
  output logic [31:0]                  RDATA,
  input  wire logic                    PIX_IN_VALID,
  output logic                         PIX_IN_READY,
  input  wire pcbg_pkg::pcbg_pix_t     PIX_IN,
  output logic                         PIX_OUT_VALID,
  input  wire logic                    PIX_OUT_READY,
  output pcbg_pkg::pcbg_pix_t          PIX_OUT
);
  import pcbg_pkg::*;
  logic [PIX_W-1:0]  ceil_r [NCH+1];
  logic [PIX_W-1:0]  ceil_nxt [NCH+1];
  logic [GAIN_W-1:0] gain_r [NCH];
  logic [GAIN_W-1:0] gain_nxt [NCH];
  logic [PIX_W-1:0]  lut [LUT_DEPTH];
  logic [3:0]  csel_r, csel_nxt, gsel_r, gsel_nxt;
  logic [1:0]  mode_r, mode_nxt;
  logic        gam_r, gam_nxt, ready_r, ready_nxt;
  logic [9:0]  lidx_r, lidx_nxt, target_r, target_nxt;
  logic [31:0] rdata_nxt;
  logic        s_valid, s_ready;
  pcbg_pix_t   s_pix;
  logic        v1_r, v1_nxt, v2_r, v2_nxt;
  pcbg_pix_t   p1_r, p1_nxt, p2_r, p2_nxt;
  logic        ovalid_r, ovalid_nxt;
  pcbg_pix_t   opix_r, opix_nxt;
  logic        adv, lut_we;
  logic [GAIN_W+PIX_W-1:0] prod;
  logic [PIX_W-1:0] bal, ceil_ch, g_out;
  logic [2:0]  gidx;

  pcbg_fifo #(.W($bits(pcbg_pix_t)), .D(FIFO_DEPTH)) u_fifo (
    .clk      (CORE_CLK),
    .rst_n    (RST_N),
    .in_valid (PIX_IN_VALID),
    .in_ready (s_ready),
    .in_data  (PIX_IN),
    .out_valid(s_valid),
    .out_ready(adv),
    .out_data (s_pix)
  );

  // pipeline stalls as a whole when the sink pushes back
  assign adv = !ovalid_r || PIX_OUT_READY;
  assign gidx = s_pix.chan[2:0] - 3'h1;

  always_comb begin
    prod = s_pix.data * gain_r[gidx];
    v1_nxt = v1_r;
    p1_nxt = p1_r;
    v2_nxt = v2_r;
    p2_nxt = p2_r;
    ovalid_nxt = ovalid_r;
    opix_nxt = opix_r;
    bal = s_pix.data;
    if (s_pix.chan != SEL_ALL && s_pix.chan <= SEL_TAP2) begin
      if (prod[GAIN_W+PIX_W-1:GAIN_FRAC+PIX_W] != '0) begin // R13
        bal = PIX_MAX; // R13
      end else begin
        bal = prod[GAIN_FRAC+PIX_W-1:GAIN_FRAC]; // R6
      end
    end
    g_out = gam_r ? lut[p1_r.data] : p1_r.data; // R11
    ceil_ch = (p2_r.chan <= SEL_TAP2) ? ceil_r[p2_r.chan] : CEIL_RST; // R2
    if (adv) begin
      v1_nxt = s_valid;
      p1_nxt = '{data: bal, chan: s_pix.chan};
      v2_nxt = v1_r;
      p2_nxt = '{data: g_out, chan: p1_r.chan};
      ovalid_nxt = v2_r;
      opix_nxt.chan = p2_r.chan;
      opix_nxt.data = p2_r.data;
      if (opix_nxt.data > ceil_r[SEL_ALL]) begin // R4
        opix_nxt.data = ceil_r[SEL_ALL]; // R1
      end
      if (opix_nxt.data > ceil_ch) begin // R2
        opix_nxt.data = ceil_ch; // R1
      end
    end
  end

  // register file and auto balance
  always_comb begin
    csel_nxt = csel_r;
    gsel_nxt = gsel_r;
    mode_nxt = mode_r;
    gam_nxt = gam_r;
    lidx_nxt = lidx_r;
    target_nxt = target_r;
    ready_nxt = s_ready;
    lut_we = 1'b0;
    rdata_nxt = 32'h0000_0000;
    for (int i = 0; i <= NCH; i++) begin
      ceil_nxt[i] = ceil_r[i];
    end
    for (int i = 0; i < NCH; i++) begin
      gain_nxt[i] = gain_r[i];
    end
    // crude step toward target; convergence within tolerance ends a once run
    if ((mode_r == MODE_ONCE || mode_r == MODE_CONT) && adv && s_valid
        && s_pix.chan != SEL_ALL && s_pix.chan <= SEL_TAP2) begin // R9
      if ({1'b0, s_pix.data} + {1'b0, AUTO_TOL} < {1'b0, target_r} && gain_r[gidx] != 16'hFFFF) begin
        gain_nxt[gidx] = gain_r[gidx] + 16'h0001;
      end else if ({1'b0, s_pix.data} > {1'b0, target_r} + {1'b0, AUTO_TOL} && gain_r[gidx] > 16'h0001) begin
        gain_nxt[gidx] = gain_r[gidx] - 16'h0001; // R6
      end else if (mode_r == MODE_ONCE) begin
        mode_nxt = MODE_OFF; // R8
      end
    end
    if (BUS.wr) begin
      if (BUS.addr == ADR_CEIL_SEL) begin
        csel_nxt = BUS.wdata[3:0];
      end else if (BUS.addr == ADR_CEIL_INT && csel_r <= SEL_TAP2) begin
        ceil_nxt[csel_r] = BUS.wdata[PIX_W-1:0]; // R3
      end else if (BUS.addr == ADR_CEIL_PHYS && csel_r <= SEL_TAP2) begin
        ceil_nxt[csel_r] = PIX_W'(BUS.wdata >> PHYS_SHIFT); // R3
      end else if (BUS.addr == ADR_GAIN_SEL && BUS.wdata[3:0] != SEL_ALL
                   && BUS.wdata[3:0] <= SEL_TAP2) begin
        gsel_nxt = BUS.wdata[3:0]; // R5
      end else if (BUS.addr == ADR_GAIN && BUS.wdata[GAIN_W-1:0] != '0) begin
        gain_nxt[gsel_r[2:0] - 3'h1] = BUS.wdata[GAIN_W-1:0]; // R7
      end else if (BUS.addr == ADR_AUTO_MODE) begin
        mode_nxt = BUS.wdata[1:0]; // R10
      end else if (BUS.addr == ADR_GAMMA_EN) begin
        gam_nxt = BUS.wdata[0];
      end else if (BUS.addr == ADR_LUT_IDX && !gam_r) begin
        lidx_nxt = BUS.wdata[9:0]; // R12
      end else if (BUS.addr == ADR_LUT_VAL) begin
        lut_we = 1'b1; // R14
        lidx_nxt = lidx_r + 10'h001;
      end else if (BUS.addr == ADR_AUTO_TARGET) begin
        target_nxt = BUS.wdata[PIX_W-1:0];
      end
    end
    if (BUS.rd) begin
      if (BUS.addr == ADR_CEIL_SEL) begin
        rdata_nxt = {28'h0, csel_r};
      end else if (BUS.addr == ADR_CEIL_INT && csel_r <= SEL_TAP2) begin
        rdata_nxt = {22'h0, ceil_r[csel_r]}; // R3
      end else if (BUS.addr == ADR_CEIL_PHYS && csel_r <= SEL_TAP2) begin
        rdata_nxt = {20'h0, ceil_r[csel_r], 2'h0}; // R3
      end else if (BUS.addr == ADR_GAIN_SEL) begin
        rdata_nxt = {28'h0, gsel_r};
      end else if (BUS.addr == ADR_GAIN) begin
        rdata_nxt = {16'h0, gain_r[gsel_r[2:0] - 3'h1]};
      end else if (BUS.addr == ADR_AUTO_MODE) begin
        rdata_nxt = {30'h0, mode_r};
      end else if (BUS.addr == ADR_GAMMA_EN) begin
        rdata_nxt = {31'h0, gam_r};
      end else if (BUS.addr == ADR_LUT_IDX) begin
        rdata_nxt = {22'h0, lidx_r};
      end else if (BUS.addr == ADR_LUT_VAL && !gam_r) begin
        rdata_nxt = {22'h0, lut[lidx_r]}; // R12
      end else if (BUS.addr == ADR_STATUS) begin
        rdata_nxt = {28'h0, s_valid, ovalid_r, !s_ready, mode_r != MODE_OFF};
      end else if (BUS.addr == ADR_AUTO_TARGET) begin
        rdata_nxt = {22'h0, target_r};
      end
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (lut_we) begin
      lut[lidx_r] <= BUS.wdata[PIX_W-1:0]; // R14
    end
    if (!RST_N) begin
      for (int i = 0; i <= NCH; i++) begin
        ceil_r[i] <= CEIL_RST;
      end
      for (int i = 0; i < NCH; i++) begin
        gain_r[i] <= GAIN_RST;
      end
      csel_r <= SEL_ALL;
      gsel_r <= SEL_RED;
      mode_r <= MODE_OFF;
      gam_r <= 1'b0;
      lidx_r <= '0;
      target_r <= TARGET_RST;
      RDATA <= 32'h0000_0000;
      ready_r <= 1'b0;
      v1_r <= 1'b0;
      v2_r <= 1'b0;
      p1_r <= '0;
      p2_r <= '0;
      ovalid_r <= 1'b0;
      opix_r <= '0;
    end else begin
      ceil_r <= ceil_nxt;
      gain_r <= gain_nxt;
      csel_r <= csel_nxt;
      gsel_r <= gsel_nxt;
      mode_r <= mode_nxt;
      gam_r <= gam_nxt;
      lidx_r <= lidx_nxt;
      target_r <= target_nxt;
      RDATA <= rdata_nxt;
      ready_r <= ready_nxt;
      v1_r <= v1_nxt;
      v2_r <= v2_nxt;
      p1_r <= p1_nxt;
      p2_r <= p2_nxt;
      ovalid_r <= ovalid_nxt;
      opix_r <= opix_nxt;
    end
  end

  // registered copy of fifo ready; one extra free slot is not guaranteed, so senders see it a cycle late
  assign PIX_IN_READY = ready_r;
  assign PIX_OUT_VALID = ovalid_r;
  assign PIX_OUT = opix_r;
endmodule // pcbg_top
`default_nettype wire

// *** pcbg_monitor.sv ***
// port assertions for the pixel clip, balance and gamma stage
`timescale 1ns/1ns
`default_nettype none
module pcbg_monitor (
  input wire logic                CORE_CLK,
  input wire logic                RST_N,
  input wire pcbg_pkg::pcbg_bus_t BUS,
  input wire logic [31:0]         RDATA,
  input wire logic                PIX_OUT_VALID,
  input wire logic                PIX_OUT_READY,
  input wire pcbg_pkg::pcbg_pix_t PIX_OUT
);
  import pcbg_pkg::*;
  logic [3:0]       sel_r;
  logic [3:0]       gsel_r;
  logic [PIX_W-1:0] ceil_r;
  logic [1:0]       mode_r;
  // mode once stands for unknown, since the device clears it by itself
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      sel_r  <= SEL_ALL;
      gsel_r <= SEL_RED;
      ceil_r <= CEIL_RST;
      mode_r <= MODE_OFF;
    end else if (BUS.wr) begin
      case (BUS.addr)
        ADR_CEIL_SEL: sel_r <= BUS.wdata[3:0];
        ADR_GAIN_SEL: if (BUS.wdata[3:0] inside {[1:8]}) gsel_r <= BUS.wdata[3:0];
        ADR_AUTO_MODE: mode_r <= BUS.wdata[1:0];
        ADR_CEIL_INT: if (sel_r == SEL_ALL) ceil_r <= BUS.wdata[PIX_W-1:0];
        ADR_CEIL_PHYS: if (sel_r == SEL_ALL) ceil_r <= BUS.wdata[PIX_W+1:2];
        default: ;
      endcase
    end
  end
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RST_N);
  sequence s_rd(logic [7:0] a);
    BUS.rd && BUS.addr == a;
  endsequence
  a_reset_quiet: assert property (disable iff (1'b0) !RST_N |=> !PIX_OUT_VALID && RDATA == '0)
    else $error("outputs not quiet in reset");
  a_rdata_idle: assert property (!$past(BUS.rd) |-> RDATA == '0)
    else $error("read data outside read slot");
  a_out_hold: assert property (PIX_OUT_VALID && !PIX_OUT_READY |=> PIX_OUT_VALID && $stable(PIX_OUT))
    else $error("stalled pixel changed");
  a_out_ceiling: assert property (PIX_OUT_VALID |-> PIX_OUT.data <= ceil_r)
    else $error("pixel above ceiling");
  a_ceil_int: assert property (s_rd(ADR_CEIL_INT) ##0 sel_r == SEL_ALL |=> RDATA == 32'(ceil_r))
    else $error("integer ceiling readback wrong");
  a_ceil_phys: assert property (s_rd(ADR_CEIL_PHYS) ##0 sel_r == SEL_ALL |=> RDATA == 32'(ceil_r) << 2)
    else $error("physical ceiling readback wrong");
  a_gsel_kept: assert property (s_rd(ADR_GAIN_SEL) |=> RDATA == 32'(gsel_r))
    else $error("gain select readback wrong");
  a_mode_kept: assert property (s_rd(ADR_AUTO_MODE) ##0 mode_r != MODE_ONCE |=> RDATA == 32'(mode_r))
    else $error("mode readback wrong");
endmodule // pcbg_monitor
bind pcbg_top pcbg_monitor u_mon (.CORE_CLK(CORE_CLK), .RST_N(RST_N), .BUS(BUS), .RDATA(RDATA),
  .PIX_OUT_VALID(PIX_OUT_VALID), .PIX_OUT_READY(PIX_OUT_READY), .PIX_OUT(PIX_OUT));
`default_nettype wire

// *** pcbg_sensor.sv ***
// sensor front end model feeding pixels
`timescale 1ns/1ns
`default_nettype none
module pcbg_sensor #(
  parameter int GAP = 1
) (
  input  wire logic           clk,
  input  wire logic           rst_n,
  input  wire logic           ready,
  output logic                valid,
  output pcbg_pkg::pcbg_pix_t pix
);
  import pcbg_pkg::*;
  pcbg_pix_t q[$];
  int        idle = 0;
  // one word then a rest, so the lagging ready is fresh before the next
  always @(posedge clk) begin
    if (!rst_n) begin
      valid <= 1'b0;
      pix   <= '0;
      idle  <= 0;
    end else if (valid) begin
      valid <= 1'b0;
      pix   <= ~pix;
      idle  <= GAP;
    end else if (idle > 0) begin
      idle <= idle - 1;
    end else if (rst_n && ready && q.size() > 0) begin
      valid <= 1'b1;
      pix   <= q.pop_front();
    end
  end
endmodule // pcbg_sensor
`default_nettype wire

// *** test_pixel_clip_balance_gamma.sv ***
// testbench for the pixel clip, balance and gamma stage
`timescale 1ns/1ns
`default_nettype none
module test_pixel_clip_balance_gamma;
  import pcbg_pkg::*;
  logic        clk, rst_n, piv, pir, pov, por;
  logic [31:0] rdata, d;
  pcbg_bus_t   bus;
  pcbg_pix_t   pin, pout, p, outq[$];
  int          n_errors = 0;
  int          num_checks = 0;
  pcbg_top dut (.CORE_CLK(clk), .RST_N(rst_n), .BUS(bus), .RDATA(rdata), .PIX_IN_VALID(piv),
    .PIX_IN_READY(pir), .PIX_IN(pin), .PIX_OUT_VALID(pov), .PIX_OUT_READY(por), .PIX_OUT(pout));
  pcbg_sensor #(.GAP(1)) sens (.clk(clk), .rst_n(rst_n), .ready(pir), .valid(piv), .pix(pin));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) if (pov && por) outq.push_back(pout);
  task automatic chk(input logic [31:0] got, exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk) bus <= '{a, v, 1'b1, 1'b0};
    @(posedge clk) bus <= '0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk) bus <= '{a, 32'h0, 1'b0, 1'b1};
    @(posedge clk) bus <= '0;
    #1 d = rdata;
  endtask
  // send one pixel and wait a bounded time for it
  task automatic px(input logic [3:0] c, input logic [PIX_W-1:0] v);
    sens.q.push_back('{v, c});
    d = 'x;
    repeat (60) if (outq.size() == 0) @(posedge clk);
    if (outq.size() != 0) begin
      p = outq.pop_front();
      d = 32'(p.data);
    end
  endtask
  task automatic t_gain;
    for (int k = 1; k <= 8; k++) begin
      wr(ADR_GAIN_SEL, k);
      rd(ADR_GAIN_SEL);
      chk(d, k);
    end
    wr(ADR_GAIN_SEL, SEL_BLUE);
    wr(ADR_GAIN, 32'h2000);
    wr(ADR_GAIN, 32'h0);
    rd(ADR_GAIN);
    chk(d, 32'h2000);
    wr(ADR_GAIN_SEL, 32'h0);
    rd(ADR_GAIN_SEL);
    chk(d, SEL_BLUE);
    px(SEL_BLUE, 10'h50);
    chk(d, 32'hA0);
    px(SEL_BLUE, 10'h300);
    chk(d, PIX_MAX);
    px(SEL_RED, 10'h50);
    chk(d, 32'h50);
    $display("gain test done");
  endtask
  task automatic t_gamma;
    wr(ADR_LUT_IDX, 32'h40);
    wr(ADR_LUT_VAL, 32'h123);
    wr(ADR_LUT_VAL, 32'h0AB);
    wr(ADR_GAMMA_EN, 32'h1);
    px(SEL_Y, 10'h41);
    chk(d, 32'hAB);
    px(SEL_Y, 10'h40);
    chk(d, 32'h123);
    rd(ADR_LUT_VAL);
    chk(d, 32'h0);
    wr(ADR_LUT_IDX, 32'h0);
    rd(ADR_LUT_IDX);
    chk(d, 32'h42);
    wr(ADR_GAMMA_EN, 32'h0);
    $display("gamma test done");
  endtask
  // stall the sink so the buffer fills and the sensor must wait
  task automatic t_fifo;
    por <= 1'b0;
    for (int k = 0; k < 24; k++) sens.q.push_back('{10'(k), SEL_Y});
    for (int n = 0; n < 300 && sens.q.size() > 0; n++) @(posedge clk);
    rd(ADR_STATUS);
    chk(d[1], 1'b1);
    chk(pir, 1'b0);
    @(posedge clk) por <= 1'b1;
    for (int n = 0; n < 300 && outq.size() < 24; n++) @(posedge clk);
    chk(outq.size(), 24);
    foreach (outq[k]) chk(outq[k].data, k);
    outq.delete();
    $display("fifo test done");
  endtask
  task automatic t_modes;
    logic [1:0] m[3] = '{MODE_OFF, MODE_CONT, MODE_VENDOR};
    foreach (m[i]) begin
      wr(ADR_AUTO_MODE, m[i]);
      px(SEL_RED, 10'h100);
      rd(ADR_AUTO_MODE);
      chk(d, m[i]);
    end
    wr(ADR_GAIN_SEL, SEL_RED);
    rd(ADR_GAIN);
    chk(d, 32'h1001);
    rd(ADR_AUTO_TARGET);
    chk(d, 32'(TARGET_RST));
    wr(ADR_AUTO_MODE, MODE_ONCE);
    px(SEL_RED, 10'h100);
    rd(ADR_AUTO_MODE);
    chk(d, MODE_ONCE);
    px(SEL_RED, 10'h200);
    rd(ADR_AUTO_MODE);
    chk(d, MODE_OFF);
    $display("mode test done");
  endtask
  task automatic t_clip;
    wr(ADR_CEIL_SEL, SEL_ALL);
    wr(ADR_CEIL_INT, 32'h100);
    rd(ADR_CEIL_PHYS);
    chk(d, 32'h400);
    wr(ADR_CEIL_PHYS, 32'h200);
    rd(ADR_CEIL_INT);
    chk(d, 32'h80);
    px(SEL_RED, 10'h3FF);
    chk(d, 32'h80);
    wr(ADR_CEIL_SEL, SEL_GREEN);
    wr(ADR_CEIL_INT, 32'h40);
    px(SEL_GREEN, 10'h3FF);
    chk(d, 32'h40);
    px(SEL_Y, 10'h60);
    chk(d, 32'h60);
    wr(ADR_CEIL_SEL, SEL_ALL);
    rd(ADR_CEIL_INT);
    chk(d, 32'h80);
    $display("clip test done");
  endtask
  task automatic wrap_up;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    rst_n = 1'b0;
    bus = '0;
    por = 1'b1;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    t_gain;
    t_gamma;
    t_fifo;
    t_modes;
    t_clip;
    wrap_up;
  end
  // the whole run needs a few hundred cycles
  initial begin
    #200000;
    n_errors++;
    wrap_up;
  end
endmodule // test_pixel_clip_balance_gamma
`default_nettype wire
